// [logic/pmtr_pkg.sv]
package pmtr_pkg;
    localparam int          PMTR_ADDR_W    = 10;
    localparam int          PMTR_WORD_W    = 14;
    localparam int          PMTR_DEPTH     = 1024;
    localparam int          PMTR_BYTE_W    = 8;
    localparam int          PMTR_HIGH_W    = PMTR_WORD_W - PMTR_BYTE_W;
    localparam int          PMTR_PAGE_W    = PMTR_ADDR_W - PMTR_BYTE_W;
    localparam logic [9:0]  PMTR_RESET_VEC = 10'h000;
    localparam logic [9:0]  PMTR_LAST_PAGE = 10'h300;
    localparam logic [7:0]  PMTR_HIGH_RST  = 8'h00;
    localparam int          PMTR_TBL_CYC   = 2;

    typedef enum logic [1:0] {
        PMTR_IDLE,
        PMTR_FETCH,
        PMTR_DONE
    } pmtr_state_e;
endpackage

// [logic/pmtr_table_read.sv]
// How it works
// - Program store holds 1K words of 14 bits, addressed by program counter.
// - Any reset loads the program counter with address 000H.
// - Table data in the current page or the last page, addressed through a separate table pointer.
// - Table reads write the low byte into the named data register.
// - Table reads load upper word bits into high latch; unused bits read 0.
// - Current-page read uses the PC page plus the table pointer offset.
// - Last-page read uses page starting 300H plus the table pointer offset.
// - The high latch is read-only; software cannot write it.
// - Every table instruction takes two instruction cycles.
// - Programming moves store and EEPROM data serially over data and clock lines.
// - Debug data pin is bidirectional, debug clock input-only.
// - Debug pins double as the in-circuit programming pins.
// - Only the low 8 PC bits are directly readable and writable.
// - A page spans 256 words, covered by an 8-bit pointer.
`timescale 1ns/100ps
`default_nettype none
module pmtr_table_read
    import pmtr_pkg::*;
#(
    parameter int ADDR_W = PMTR_ADDR_W,
    parameter int WORD_W = PMTR_WORD_W
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   pc_advance_i,
    input  wire logic                   pc_low_wr_i,
    input  wire logic [PMTR_BYTE_W-1:0] pc_low_wdata_i,
    input  wire logic                   pc_jump_i,
    input  wire logic [ADDR_W-1:0]      pc_jump_addr_i,
    input  wire logic [PMTR_BYTE_W-1:0] table_ptr_i,
    input  wire logic                   table_read_i,
    input  wire logic                   table_read_final_page_i,
    input  wire logic [PMTR_BYTE_W-1:0] dest_reg_i,
    input  wire logic                   store_wr_i,
    input  wire logic [ADDR_W-1:0]      store_wr_addr_i,
    input  wire logic [WORD_W-1:0]      store_wr_data_i,
    output logic [ADDR_W-1:0]           pc_o,
    output logic [PMTR_BYTE_W-1:0]      pc_low_byte_o,
    output logic [WORD_W-1:0]           instr_o,
    output logic                        busy_o,
    output logic                        dm_wr_o,
    output logic [PMTR_BYTE_W-1:0]      dm_addr_o,
    output logic [PMTR_BYTE_W-1:0]      dm_wdata_o,
    output logic [PMTR_BYTE_W-1:0]      table_high_latch_o
);
    // Program store; writes come from the programming engine outside this block.
    logic [WORD_W-1:0] store [PMTR_DEPTH];
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] tbl_addr;
    logic [ADDR_W-1:0] next_tbl_addr;
    logic [PMTR_BYTE_W-1:0] dest;
    logic [WORD_W-1:0] tbl_word;
    pmtr_state_e state;

    // The serial programming engine and the debug port share one clock pin and one
    // two-way data pin outside this block. Both reach the store only through this
    // write port, so the table path never needs to know which of them is active.
    always_ff @(posedge clk_sys_i) begin
        if (store_wr_i) begin
            store[store_wr_addr_i] <= store_wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        instr_o  <= store[pc];
        tbl_word <= store[tbl_addr];
    end

    // Program counter: only the low byte is writable by software.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pc <= PMTR_RESET_VEC;
        end else if (pc_jump_i) begin
            pc <= pc_jump_addr_i;
        end else if (pc_low_wr_i) begin
            pc <= {pc[ADDR_W-1:PMTR_BYTE_W], pc_low_wdata_i};
        end else if (pc_advance_i && state == PMTR_IDLE) begin
            pc <= ADDR_W'(pc + 1'b1);
        end
    end
    assign pc_o          = pc;
    assign pc_low_byte_o = pc[PMTR_BYTE_W-1:0];

    // Page bits on top, pointer below; a page is 256 words.
    // The current page is the one the program counter holds at the request edge.
    // A jump in the same cycle therefore does not move the table.
    always_comb begin
        if (table_read_final_page_i) begin
            next_tbl_addr = {PMTR_LAST_PAGE[ADDR_W-1:PMTR_BYTE_W], table_ptr_i};
        end else begin
            next_tbl_addr = {pc[ADDR_W-1:PMTR_BYTE_W], table_ptr_i};
        end
    end

    // Two-cycle sequence: capture address, then the store access cycle.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state    <= PMTR_IDLE;
            tbl_addr <= PMTR_RESET_VEC;
            dest     <= 8'h00;
        end else begin
            case (state)
                PMTR_IDLE: begin
                    if (table_read_i) begin
                        tbl_addr <= next_tbl_addr;
                        dest     <= dest_reg_i;
                        state    <= PMTR_FETCH;
                    end
                end
                PMTR_FETCH: state <= PMTR_DONE;
                PMTR_DONE:  state <= PMTR_IDLE;
                default:    state <= PMTR_IDLE;
            endcase
        end
    end
    assign busy_o = (state != PMTR_IDLE);

    // The latch has no write port, so software cannot alter or restore it.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            table_high_latch_o <= PMTR_HIGH_RST;
            dm_wr_o            <= 1'b0;
            dm_addr_o          <= 8'h00;
            dm_wdata_o         <= 8'h00;
        end else begin
            dm_wr_o <= 1'b0;
            if (state == PMTR_DONE) begin
                dm_wr_o            <= 1'b1;
                dm_addr_o          <= dest;
                dm_wdata_o         <= tbl_word[PMTR_BYTE_W-1:0];
                table_high_latch_o <= {2'b00, tbl_word[WORD_W-1:PMTR_BYTE_W]};
            end
        end
    end

    property p_reset_vec;
        @(posedge clk_sys_i) !rst_n_i |=> pc == 10'h000;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector");

    property p_two_cycles;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (state == PMTR_IDLE && table_read_i) |=> busy_o ##1 busy_o ##1 (dm_wr_o && !busy_o);
    endproperty
    a_two_cycles: assert property (p_two_cycles) else $error("table read timing wrong");

    property p_final_page;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (state == PMTR_IDLE && table_read_i && table_read_final_page_i)
            |=> tbl_addr == {2'b11, $past(table_ptr_i)};
    endproperty
    a_final_page: assert property (p_final_page) else $error("last page address wrong");

    property p_cur_page;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (state == PMTR_IDLE && table_read_i && !table_read_final_page_i && !pc_jump_i)
            |=> tbl_addr[7:0] == $past(table_ptr_i) && tbl_addr[9:8] == $past(pc[9:8]);
    endproperty
    a_cur_page: assert property (p_cur_page) else $error("current page address wrong");

    property p_high_zero;
        @(posedge clk_sys_i) disable iff (!rst_n_i) table_high_latch_o[7:6] == 2'b00;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("unused latch bits set");

    property p_latch_hold;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !dm_wr_o |-> $stable(table_high_latch_o);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed without read");

    property p_low_byte;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        dm_wr_o |-> dm_wdata_o == $past(tbl_word[7:0]) && dm_addr_o == $past(dest);
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte wrong");

    property p_pc_low_wr;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (pc_low_wr_i && !pc_jump_i) |=> pc_low_byte_o == $past(pc_low_wdata_i)
            && pc[9:8] == $past(pc[9:8]);
    endproperty
    a_pc_low_wr: assert property (p_pc_low_wr) else $error("pc low write wrong");

    // A request seen while busy must leave the captured address and target alone.
    property p_refuse_busy;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        busy_o |=> $stable(tbl_addr) && $stable(dest);
    endproperty
    a_refuse_busy: assert property (p_refuse_busy) else $error("request taken while busy");

    property p_pc_busy;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (busy_o && pc_advance_i && !pc_jump_i && !pc_low_wr_i) |=> $stable(pc);
    endproperty
    a_pc_busy: assert property (p_pc_busy) else $error("pc stepped during table access");

    property p_pc_step;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (!busy_o && pc_advance_i && !pc_jump_i && !pc_low_wr_i)
            |=> pc == ADDR_W'($past(pc) + 1'b1);
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc step wrong");

    property p_jump_load;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        pc_jump_i |=> pc == $past(pc_jump_addr_i);
    endproperty
    a_jump_load: assert property (p_jump_load) else $error("pc jump wrong");

    property p_dm_pulse;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        dm_wr_o |=> !dm_wr_o;
    endproperty
    a_dm_pulse: assert property (p_dm_pulse) else $error("data write longer than a cycle");

    c_final: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        table_read_i && table_read_final_page_i && state == PMTR_IDLE);
    c_cur: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        table_read_i && !table_read_final_page_i && state == PMTR_IDLE);
    c_b2b: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        dm_wr_o && table_read_i && !busy_o);
    // A request that arrives while the access is under way is dropped silently.
    c_refused: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        busy_o && table_read_i);
endmodule // pmtr_table_read
`default_nettype wire

// [dv/pmtr_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pmtr_cpu_model (
    input  wire logic      clk_sys_i,
    input  wire logic      busy_i,
    output var logic       step_o,
    output var logic       low_wr_o,
    output var logic [7:0] low_o,
    output var logic       jump_o,
    output var logic [9:0] jaddr_o,
    output var logic       rd_o,
    output var logic       fin_o,
    output var logic [7:0] ptr_o,
    output var logic [7:0] dst_o
);
    initial {step_o, low_wr_o, low_o, jump_o, jaddr_o, rd_o, fin_o, ptr_o, dst_o} = '0;
    // Select k: 0 steps, 1 writes the low byte, 2 jumps. Released buses show the inverse.
    task automatic pulse(input int k, input logic [9:0] v);
        @(negedge clk_sys_i);
        {step_o, low_wr_o, jump_o} = 3'b100 >> k;
        {low_o, jaddr_o} = {v[7:0], v};
        @(negedge clk_sys_i);
        {step_o, low_wr_o, jump_o} = 3'b000;
        {low_o, jaddr_o} = ~{v[7:0], v};
    endtask
    // Reads come from main code one at a time, never from a handler.
    task automatic tabrd(input logic [7:0] p, input logic f, input logic [7:0] d);
        @(negedge clk_sys_i);
        while (busy_i !== 1'b0) @(negedge clk_sys_i);
        {rd_o, fin_o, ptr_o, dst_o} = {1'b1, f, p, d};
        @(negedge clk_sys_i);
        {rd_o, fin_o, ptr_o, dst_o} = {1'b0, ~f, ~p, ~d};
    endtask
    // Keeps the read strobe up after it was taken and steps the counter meanwhile.
    task automatic tabrd_two(input logic [7:0] p, input logic f, input logic [7:0] d,
                             input logic [7:0] p2, input logic [7:0] d2);
        @(negedge clk_sys_i);
        while (busy_i !== 1'b0) @(negedge clk_sys_i);
        {rd_o, fin_o, ptr_o, dst_o} = {1'b1, f, p, d};
        @(negedge clk_sys_i);
        {step_o, fin_o, ptr_o, dst_o} = {1'b1, ~f, p2, d2};
    endtask
    task automatic tabrd_stop();
        @(negedge clk_sys_i);
        {step_o, rd_o, fin_o, ptr_o, dst_o} = {2'b00, ~fin_o, ~ptr_o, ~dst_o};
    endtask
endmodule // pmtr_cpu_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk_sys_i, rst_n_i, stp, lwr, jmp, rd, fin, busy, dm_wr, swr;
    logic [7:0]  low, ptr, dst, pc_low_byte, dm_addr, dm_wdata, latch;
    logic [9:0]  ja, pc, swa;
    logic [13:0] swd, instr;
    int          bad_count = 0, samples_checked = 0, cycles = 0;
    pmtr_table_read dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pc_advance_i(stp),
        .pc_low_wr_i(lwr), .pc_low_wdata_i(low), .pc_jump_i(jmp), .pc_jump_addr_i(ja),
        .table_ptr_i(ptr), .table_read_i(rd), .table_read_final_page_i(fin),
        .dest_reg_i(dst), .store_wr_i(swr), .store_wr_addr_i(swa), .store_wr_data_i(swd),
        .pc_o(pc), .pc_low_byte_o(pc_low_byte), .instr_o(instr), .busy_o(busy), .dm_wr_o(dm_wr),
        .dm_addr_o(dm_addr), .dm_wdata_o(dm_wdata), .table_high_latch_o(latch));
    pmtr_cpu_model cpu (.clk_sys_i(clk_sys_i), .busy_i(busy), .step_o(stp), .low_wr_o(lwr),
        .low_o(low), .jump_o(jmp), .jaddr_o(ja), .rd_o(rd), .fin_o(fin), .ptr_o(ptr),
        .dst_o(dst));
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string n, input logic [13:0] s, input logic [13:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 500) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic do_reset();
        rst_n_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        chk("pc", 14'(pc), 14'h000);
        chk("latch", 14'(latch), 14'h000);
        chk("busy", 14'({busy, dm_wr}), 14'h000);
        chk("dm_addr reset", 14'(dm_addr), 14'h000);
        chk("dm_wdata reset", 14'(dm_wdata), 14'h000);
        $display("test reset done");
    endtask
    // The programmer side owns the store contents and loads them through the write hook.
    task automatic ld(input logic [9:0] a, input logic [13:0] d);
        @(negedge clk_sys_i);
        {swr, swa, swd} = {1'b1, a, d};
        @(negedge clk_sys_i);
        swr = 1'b0;
    endtask
    // Called on the falling edge just after the taking edge.
    // The answer must land on the second edge after the taking edge, not earlier.
    task automatic t_ans(input logic [7:0] d, input logic [13:0] w);
        chk("busy c1", 14'({busy, dm_wr}), 14'h002);
        @(negedge clk_sys_i);
        chk("busy c2", 14'({busy, dm_wr}), 14'h002);
        @(negedge clk_sys_i);
        chk("dm_wr c3", 14'({busy, dm_wr}), 14'h001);
        chk("dm_addr", 14'(dm_addr), 14'(d));
        chk("low byte", 14'(dm_wdata), 14'(w[7:0]));
        chk("latch", 14'(latch), 14'(w[13:8]));
    endtask
    task automatic t_tab(input logic [7:0] p, input logic f, input logic [13:0] w);
        cpu.tabrd(p, f, p ^ 8'h5a);
        t_ans(p ^ 8'h5a, w);
        $display("test table read done");
    endtask
    // A second request and a counter step held during the access are refused.
    // The request is taken in the answer cycle, the step then advances once.
    task automatic t_busy();
        cpu.tabrd_two(8'h06, 1'b1, 8'h21, 8'h34, 8'h43);
        t_ans(8'h21, 14'h3abc);
        cpu.tabrd_stop();
        chk("pc held while busy", 14'(pc), 14'h1f1);
        t_ans(8'h43, 14'h15a7);
        $display("test refused request done");
    endtask
    initial begin
        {rst_n_i, swr, swa, swd} = '0;
        do_reset();
        ld(10'h3ff, 14'h2c3d);
        ld(10'h306, 14'h3abc);
        ld(10'h305, 14'h0f0f);
        ld(10'h134, 14'h15a7);
        cpu.pulse(2, 10'h3ff);
        @(negedge clk_sys_i);
        chk("instr", instr, 14'h2c3d);
        cpu.pulse(2, 10'h1f0);
        t_tab(8'h06, 1'b1, 14'h3abc);
        t_tab(8'h05, 1'b1, 14'h0f0f);
        t_tab(8'h34, 1'b0, 14'h15a7);
        t_busy();
        cpu.pulse(2, 10'h2ff);
        cpu.pulse(0, 10'h000);
        chk("pc step", 14'(pc), 14'h300);
        cpu.pulse(1, 10'h012);
        chk("pc low write", 14'(pc), 14'h312);
        chk("pc low byte", 14'(pc_low_byte), 14'h012);
        chk("latch held", 14'(latch), 14'h015);
        $display("test pc done");
        do_reset();
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
